// File: design/timer_capture_compare_unit.sv
// capture and compare unit beside a 16-bit timer, with an axi4-lite register slave
////////////////////////////////////////////////////////////////////////////////
// Function
// - each capture copies the full 16-bit timer count into the value pair
// - mode picks any, falling, rising, every 4th or every 16th rising edge
// - source field picks pin, comparator a, comparator b or pin-change trigger
// - every capture sets the interrupt flag; only software clears it
// - a new capture overwrites the value pair even if still unread
// - edge detector watches the pin level whatever its direction
// - prescaler clears when disabled, outside capture modes, and on reset
// - switching between prescale settings keeps the prescaler count
// - internal output is high for exactly one clock on each capture
// - internal output feeds waveform, converter, period, measure and logic units
// - capture in sleep only works while the timer has an external clock
// - compare mode matches value pair to timer count, may reset the timer
// - compare match sets the flag together with the selected output action
// - codes 0001/0010 toggle, 1000 sets, 1001 clears the output on match
// - codes 1011/1010 drive output high only while count equals value pair
// - code 1010 leaves the pin alone, only flags and drives internal output
// - writing zero to the control register clears the compare output latch
// - compare runs on the system clock and stops with it
////////////////////////////////////////////////////////////////////////////////
module timer_capture_compare_unit (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [capture_compare_pkg::AXI_ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [capture_compare_pkg::AXI_DATA_W-1:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [capture_compare_pkg::AXI_ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [capture_compare_pkg::AXI_DATA_W-1:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [capture_compare_pkg::COUNT_W-1:0] reference_timer_count, // timer count
  input wire logic module_pin_in, // pin level, asynchronous
  input wire logic comparator_a_sync_out, // comparator a, already synced
  input wire logic comparator_b_sync_out, // comparator b, already synced
  input wire logic pin_change_trigger, // pin-change trigger, same clock
  output logic module_pin_out, // pin output level
  output logic module_pin_oe_n, // pin output enable, low drives
  output logic module_output, // internal output to other units
  output logic timer_reset_req, // one-cycle request to clear the timer
  output logic module_interrupt_flag // sticky interrupt flag
);
  import capture_compare_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register and pipeline state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_held_reg, w_held_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [AXI_DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [AXI_DATA_W-1:0] rdata_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [SRC_W-1:0] src_reg;
  logic [COUNT_W-1:0] value_reg, value_next;
  logic flag_reg, flag_next;
  logic [PRESC_W-1:0] presc_cnt_reg, presc_cnt_next;
  logic pin_meta_reg, pin_sync_reg;
  logic sel_prev_reg;
  logic match_prev_reg;
  logic latch_reg, latch_next;
  logic out_reg, out_next;
  logic pin_out_reg, pin_out_next;
  logic pin_oe_n_reg, pin_oe_n_next;
  logic timer_rst_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // axi write path: address and data taken in either order
  wire aw_take = awvalid && awready_reg;
  wire w_take = wvalid && wready_reg;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire b_done = bvalid_reg && bready;
  wire wa_ctrl = aw_addr_reg == CTRL_OFFSET;
  wire wa_src = aw_addr_reg == SRC_OFFSET;
  wire wa_value = aw_addr_reg == VALUE_OFFSET;
  wire wa_status = aw_addr_reg == STATUS_OFFSET;
  wire wa_hit = wa_ctrl || wa_src || wa_value || wa_status;
  wire ctrl_wr = do_write && wa_ctrl && w_strb_reg[0];
  wire ctrl_zero_wr = ctrl_wr && (w_data_reg[CTRL_W-1:0] == CTRL_RESET);
  wire src_wr = do_write && wa_src && w_strb_reg[0];
  wire value_lo_wr = do_write && wa_value && w_strb_reg[0];
  wire value_hi_wr = do_write && wa_value && w_strb_reg[1];
  wire flag_clr = do_write && wa_status && w_strb_reg[0] && w_data_reg[STATUS_FLAG_BIT];

  // write channel handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_held_reg <= 1'b1;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end else if (b_done) begin
        awready_reg <= 1'b1;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_held_reg <= 1'b1;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end else if (b_done) begin
        wready_reg <= 1'b1;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wa_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // write address and data capture, no reset needed
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_reg <= awaddr;
    end
    if (w_take) begin
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control fields
  wire en = ctrl_reg[CTRL_EN_BIT];
  wire oe = ctrl_reg[CTRL_OE_BIT];
  wire [3:0] mode = ctrl_reg[3:0];
  wire cap_mode = (mode == MODE_CAP_ANY) || (mode == MODE_CAP_FALL)
    || (mode == MODE_CAP_RISE) || (mode == MODE_CAP_RISE4) || (mode == MODE_CAP_RISE16);
  wire presc_mode = (mode == MODE_CAP_RISE4) || (mode == MODE_CAP_RISE16);
  wire pulse_mode = (mode == MODE_CMP_PULSE) || (mode == MODE_CMP_SOFT);
  wire cmp_mode = (mode == MODE_CMP_TOGGLE_RST) || (mode == MODE_CMP_TOGGLE)
    || (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLEAR) || pulse_mode;

  // software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      src_reg <= SRC_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= w_data_reg[CTRL_W-1:0] & ~(8'h01 << CTRL_OUT_BIT);
      end
      if (src_wr) begin
        src_reg <= w_data_reg[SRC_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source select, pin taken after its synchroniser
  wire sel_level = (src_reg == SRC_PIN) ? pin_sync_reg :
    (src_reg == SRC_CMP_A) ? comparator_a_sync_out :
    (src_reg == SRC_CMP_B) ? comparator_b_sync_out : pin_change_trigger;

  // capture input: pin synchronised whatever its direction, then selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= module_pin_in;
      pin_sync_reg <= pin_meta_reg;
      sel_prev_reg <= sel_level;
    end
  end

  // edge detect on the selected level
  wire sel_rise = sel_level && !sel_prev_reg;
  wire sel_fall = !sel_level && sel_prev_reg;

  // event qualification per mode
  wire presc4_hit = sel_rise && (presc_cnt_reg[1:0] == PRESC4_LAST);
  wire presc16_hit = sel_rise && (presc_cnt_reg == PRESC16_LAST);
  wire capture_evt = en && (
    ((mode == MODE_CAP_ANY) && (sel_rise || sel_fall)) ||
    ((mode == MODE_CAP_FALL) && sel_fall) ||
    ((mode == MODE_CAP_RISE) && sel_rise) ||
    ((mode == MODE_CAP_RISE4) && presc4_hit) ||
    ((mode == MODE_CAP_RISE16) && presc16_hit));

  // prescaler: free count of rising edges, kept across prescale changes
  always_comb begin
    presc_cnt_next = presc_cnt_reg;
    if (!en || !cap_mode) begin
      presc_cnt_next = PRESC_RESET;
    end else if (presc_mode && sel_rise) begin
      presc_cnt_next = presc_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare: equality against the timer; flag, latch and timer clear act at the start of a match, pulse modes follow the whole match
  wire match_on = en && cmp_mode && (reference_timer_count == value_reg);
  wire cmp_event = match_on && !match_prev_reg;
  wire toggle_mode = (mode == MODE_CMP_TOGGLE_RST) || (mode == MODE_CMP_TOGGLE);

  // compare output latch
  always_comb begin
    latch_next = latch_reg;
    if (ctrl_zero_wr) begin
      latch_next = 1'b0;
    end else if (cmp_event && toggle_mode) begin
      latch_next = !latch_reg;
    end else if (cmp_event && (mode == MODE_CMP_SET)) begin
      latch_next = 1'b1;
    end else if (cmp_event && (mode == MODE_CMP_CLEAR)) begin
      latch_next = 1'b0;
    end
  end

  // internal output and pin drive
  always_comb begin
    out_next = 1'b0;
    if (cap_mode) begin
      out_next = capture_evt;
    end else if (pulse_mode) begin
      out_next = match_on;
    end else if (cmp_mode) begin
      out_next = latch_next;
    end
    pin_out_next = pulse_mode ? match_on : latch_next;
    pin_oe_n_next = !(en && oe && cmp_mode && (mode != MODE_CMP_SOFT));
  end

  // value pair and flag: hardware set wins over software
  always_comb begin
    value_next = value_reg;
    if (value_lo_wr) begin
      value_next[7:0] = w_data_reg[7:0];
    end
    if (value_hi_wr) begin
      value_next[15:8] = w_data_reg[15:8];
    end
    if (capture_evt) begin
      value_next = reference_timer_count;
    end
    flag_next = (flag_reg && !flag_clr) || capture_evt || cmp_event;
  end

  // event state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt_reg <= PRESC_RESET;
      match_prev_reg <= 1'b0;
      latch_reg <= 1'b0;
      value_reg <= VALUE_RESET;
      flag_reg <= 1'b0;
    end else begin
      presc_cnt_reg <= presc_cnt_next;
      match_prev_reg <= match_on;
      latch_reg <= latch_next;
      value_reg <= value_next;
      flag_reg <= flag_next;
    end
  end

  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      timer_rst_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      timer_rst_reg <= cmp_event && ((mode == MODE_CMP_TOGGLE_RST)
        || (mode == MODE_CMP_PULSE));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi read path: one outstanding read, data registered at the take
  wire ar_take = arvalid && arready_reg;
  wire [CTRL_W-1:0] ctrl_view = ctrl_reg | ({7'h00, latch_reg} << CTRL_OUT_BIT);
  logic [AXI_DATA_W-1:0] rd_word;
  logic rd_hit;

  // read address decode
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (araddr == CTRL_OFFSET) begin
      rd_word = {24'h000000, ctrl_view};
    end else if (araddr == SRC_OFFSET) begin
      rd_word = {30'h00000000, src_reg};
    end else if (araddr == VALUE_OFFSET) begin
      rd_word = {16'h0000, value_reg};
    end else if (araddr == STATUS_OFFSET) begin
      rd_word = {31'h00000000, flag_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read channel flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // port drive, all from flops; one internal output serves every consumer
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign module_output = out_reg;
  assign module_pin_out = pin_out_reg;
  assign module_pin_oe_n = pin_oe_n_reg;
  assign timer_reset_req = timer_rst_reg;
  assign module_interrupt_flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_capture_copy;
    capture_evt |=> value_reg == $past(reference_timer_count);
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture copy wrong");

  property p_capture_flag;
    capture_evt |=> module_interrupt_flag;
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture left flag clear");

  property p_overwrite;
    (capture_evt && flag_reg) |=> (value_reg == $past(reference_timer_count)) && flag_reg;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("second capture not stored");

  property p_any_edge;
    (en && (mode == MODE_CAP_ANY) && (sel_rise || sel_fall)) |=> module_output;
  endproperty
  a_any_edge: assert property (p_any_edge) else $error("edge not captured");

  property p_rise16_gap;
    (en && (mode == MODE_CAP_RISE16) && sel_rise && (presc_cnt_reg != PRESC16_LAST))
      |-> !capture_evt;
  endproperty
  a_rise16_gap: assert property (p_rise16_gap) else $error("early prescaled capture");

  property p_presc_clear;
    (!en || !cap_mode) |=> presc_cnt_reg == PRESC_RESET;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_presc_keep;
    (en && presc_mode && !sel_rise) |=> $stable(presc_cnt_reg);
  endproperty
  a_presc_keep: assert property (p_presc_keep) else $error("prescaler count lost");

  sequence s_lone_capture;
    capture_evt ##1 (!capture_evt && cap_mode);
  endsequence
  property p_cap_pulse;
    s_lone_capture |-> module_output ##1 !module_output;
  endproperty
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse not one clock");

  property p_toggle;
    (cmp_event && toggle_mode && !ctrl_zero_wr)
      |=> (latch_reg != $past(latch_reg)) && module_interrupt_flag;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle or flag missing");

  property p_set_clear;
    (cmp_event && !ctrl_zero_wr && (mode == MODE_CMP_SET || mode == MODE_CMP_CLEAR))
      |=> latch_reg == ($past(mode) == MODE_CMP_SET);
  endproperty
  a_set_clear: assert property (p_set_clear) else $error("set or clear wrong");

  property p_pulse_level;
    (en && pulse_mode) |=> module_output == $past(reference_timer_count == value_reg);
  endproperty
  a_pulse_level: assert property (p_pulse_level) else $error("pulse level wrong");

  property p_soft_no_pin;
    (en && mode == MODE_CMP_SOFT) |=> module_pin_oe_n;
  endproperty
  a_soft_no_pin: assert property (p_soft_no_pin) else $error("soft mode drove pin");

  property p_zero_write;
    ctrl_zero_wr |=> !latch_reg ##1 !module_pin_out;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("latch not cleared");

  property p_timer_reset;
    (cmp_event && mode == MODE_CMP_PULSE) |=> timer_reset_req ##1 !timer_reset_req;
  endproperty
  a_timer_reset: assert property (p_timer_reset) else $error("timer reset pulse wrong");
endmodule

// File: design/capture_compare_pkg.sv
// constants, codes and register map of the capture and compare unit
package capture_compare_pkg;
  // widths
  localparam int COUNT_W = 16;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int PRESC_W = 4;
  localparam int CTRL_W = 8;
  localparam int SRC_W = 2;

  // register byte offsets
  localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] SRC_OFFSET = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] VALUE_OFFSET = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 8'h0c;

  // control and status register field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OE_BIT = 6;
  localparam int CTRL_OUT_BIT = 5;
  localparam int STATUS_FLAG_BIT = 0;

  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [SRC_W-1:0] SRC_RESET = 2'h0;
  localparam logic [COUNT_W-1:0] VALUE_RESET = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 4'h0;

  // prescaler terminal counts
  localparam logic [1:0] PRESC4_LAST = 2'h3;
  localparam logic [PRESC_W-1:0] PRESC16_LAST = 4'hf;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // mode field codes
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_CMP_TOGGLE_RST = 4'h1,
    MODE_CMP_TOGGLE = 4'h2,
    MODE_CAP_ANY = 4'h3,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_RISE4 = 4'h6,
    MODE_CAP_RISE16 = 4'h7,
    MODE_CMP_SET = 4'h8,
    MODE_CMP_CLEAR = 4'h9,
    MODE_CMP_SOFT = 4'ha,
    MODE_CMP_PULSE = 4'hb
  } mode_t;

  // capture source codes
  typedef enum logic [1:0] {
    SRC_PIN = 2'h0,
    SRC_CMP_A = 2'h1,
    SRC_CMP_B = 2'h2,
    SRC_PIN_CHANGE = 2'h3
  } src_t;
endpackage

// File: sim/event_source_model.sv
// far-side model: reference timer and the capture event lines
module event_source_model (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic load, // load the timer
  input wire logic [15:0] load_val, // value to load
  input wire logic [3:0] ev_lvl, // requested event levels
  input wire logic timer_reset_req, // clear request from the unit
  output logic [15:0] reference_timer_count, // timer count
  output logic module_pin_in, // pin level
  output logic comparator_a_sync_out, // comparator a
  output logic comparator_b_sync_out, // comparator b
  output logic pin_change_trigger // pin-change trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // timer stepped on the system clock: held, loaded, or cleared on request
  always_ff @(posedge aclk) begin
    if (!aresetn) reference_timer_count <= 16'h0000;
    else if (load) reference_timer_count <= load_val;
    else if (timer_reset_req) reference_timer_count <= 16'h0000;
  end
  // event lines follow the requested levels one clock later
  always_ff @(posedge aclk) begin
    {pin_change_trigger, comparator_b_sync_out, comparator_a_sync_out, module_pin_in} <= ev_lvl;
  end
endmodule

// File: sim/timer_capture_compare_unit_tb.sv
// self-checking bench for the capture and compare unit
module timer_capture_compare_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_compare_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [AXI_DATA_W-1:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] ev_lvl = 4'h0, lv = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic load = 1'b0;
  logic [COUNT_W-1:0] load_val = 16'h0000, reference_timer_count, m_val = 16'h0000;
  logic [COUNT_W-1:0] cv = 16'h0000, tv = 16'h0000;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, module_pin_in, comparator_a_sync_out;
  logic comparator_b_sync_out, pin_change_trigger, module_pin_out, module_pin_oe_n;
  logic module_output, timer_reset_req, module_interrupt_flag;
  logic [31:0] seed = 32'h0000_6894;
  int n_mismatch = 0, n_checks = 0, n_pulse = 0, cycles = 0, p0 = 0;
  int m_en = 0, m_mode = 0, m_src = 0, m_flag = 0, m_out = 0, presc = 0, caps = 0;
  int modes [8] = '{8, 0, 8, 9, 1, 2, 10, 11};
  ////////////////////////////////////////////////////////////////////////////////
  // design and far side
  timer_capture_compare_unit dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .reference_timer_count, .module_pin_in,
    .comparator_a_sync_out, .comparator_b_sync_out, .pin_change_trigger, .module_pin_out,
    .module_pin_oe_n, .module_output, .timer_reset_req, .module_interrupt_flag);
  event_source_model far_side (.aclk, .aresetn, .load, .load_val, .ev_lvl, .timer_reset_req,
    .reference_timer_count, .module_pin_in, .comparator_a_sync_out, .comparator_b_sync_out,
    .pin_change_trigger);
  // clock
  always #5 aclk = ~aclk;
  // cycle count, internal output high time, hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (module_output === 1'b1) n_pulse <= n_pulse + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1;
        bready <= 1'b0;
        chk(bresp, er);
      end
    end
  endtask
  // bus read with compare
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1;
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
      end
    end
  endtask
  // control write mirrored in the model
  task automatic cfg(input logic [7:0] c);
    wr(CTRL_OFFSET, c, RESP_OKAY);
    m_en = c[CTRL_EN_BIT];
    m_mode = c[3:0];
    if (!m_en || m_mode < 3 || m_mode > 7) presc = 0;
    if (c == 8'h00) m_out = 0;
  endtask
  // flag clear by writing one
  task automatic clr();
    wr(STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
    m_flag = 0;
  endtask
  // timer load through the far side
  task automatic tload(input logic [15:0] v);
    @(posedge aclk);
    load <= 1'b1;
    load_val <= v;
    tv = v;
    @(posedge aclk);
    load <= 1'b0;
  endtask
  // one event line change and its expected capture
  task automatic ev(input int s, input logic l);
    logic prev;
    prev = lv[s];
    lv[s] = l;
    @(posedge aclk);
    ev_lvl <= lv;
    repeat (6) @(posedge aclk);
    if (s == m_src && m_en == 1 && m_mode >= 3 && m_mode <= 7) begin
      if ((m_mode == 3 && prev != l) || (m_mode == 4 && prev && !l) || (m_mode == 5 && l && !prev)
          || (l && !prev && ((m_mode == 6 && presc % 4 == 3) || (m_mode == 7 && presc == 15)))) begin
        m_val = tv;
        m_flag = 1;
        caps++;
      end
      if (m_mode >= 6 && l && !prev) presc = (presc + 1) % 16;
    end
  endtask
  // rise and fall pulses, each at a fresh random timer value
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      tload(16'(rnd()));
      ev(s, 1'b1);
      ev(s, 1'b0);
    end
  endtask
  // timer meets the value pair for five cycles, for two in modes 1 and 11 where the match clears the timer
  task automatic hit(input int m);
    tload(cv);
    repeat (3) @(posedge aclk);
    chk(reference_timer_count, (m == 1 || m == 11) ? 16'h0000 : cv);
    tload(cv + 16'h0001);
    repeat (3) @(posedge aclk);
    m_flag = 1;
    if (m == 1 || m == 2) m_out = 1 - m_out;
    if (m == 8) m_out = 1;
    if (m == 9) m_out = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(module_pin_oe_n, 1'b1);
    chk(module_output, 1'b0);
    for (int a = 0; a < 20; a += 4) rd(a[7:0], 32'h0, a < 16 ? RESP_OKAY : RESP_SLVERR);
    wr(8'h10, 32'h0000_00ff, RESP_SLVERR);
    $display("test done: registers");
    for (int s = 0; s < 4; s++) begin
      wr(SRC_OFFSET, s, RESP_OKAY);
      m_src = s;
      rd(SRC_OFFSET, s, RESP_OKAY);
      cfg(8'hc5);
      pulse(s, 2);
      rd(VALUE_OFFSET, m_val, RESP_OKAY);
      chk(module_interrupt_flag, m_flag);
      chk(n_pulse, caps);
      clr();
      chk(module_interrupt_flag, 1'b0);
    end
    $display("test done: capture sources");
    for (int m = 3; m < 6; m++) begin
      cfg(8'h80 | m[7:0]);
      pulse(3, 2);
      rd(VALUE_OFFSET, m_val, RESP_OKAY);
      chk(n_pulse, caps);
    end
    $display("test done: edge modes");
    cfg(8'h06);
    cfg(8'h86);
    pulse(3, 3);
    cfg(8'h06);
    cfg(8'h86);
    pulse(3, 3);
    chk(n_pulse, caps);
    cfg(8'h87);
    pulse(3, 13);
    chk(n_pulse, caps);
    pulse(3, 16);
    chk(n_pulse, caps);
    rd(VALUE_OFFSET, m_val, RESP_OKAY);
    clr();
    $display("test done: prescaler");
    cv = 16'(rnd()) & 16'h7fff | 16'h0100;
    tload(cv + 16'h0001);
    wr(VALUE_OFFSET, cv, RESP_OKAY);
    foreach (modes[i]) begin
      if (modes[i] == 0) begin
        cfg(8'h00);
        chk(module_output, 1'b0);
        chk(module_pin_out, 1'b0);
      end else begin
        cfg(8'hc0 | modes[i][7:0]);
        p0 = n_pulse;
        hit(modes[i]);
        chk(module_interrupt_flag, 1'b1);
        chk(module_pin_oe_n, modes[i] == 10);
        if (modes[i] < 10) begin
          chk(module_output, m_out);
          chk(module_pin_out, m_out);
          rd(CTRL_OFFSET, 8'hc0 | modes[i] | m_out << 5, RESP_OKAY);
        end
        if (modes[i] == 10) chk(n_pulse - p0, 5);
        if (modes[i] == 11) chk(n_pulse - p0, 2);
        clr();
      end
    end
    $display("test done: compare");
    complete_run();
  end
endmodule
